// file: design/simd_mul_pkg.sv
// Purpose: shared constants and types of the packed halfword multiplier
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes: one constant per documented figure
package simd_mul_pkg;

    // ************************************************************
    // instruction fields
    // ************************************************************
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int FUNC_HI = 5;
    localparam int FUNC_LO = 0;
    localparam int SUB_HI = 10;
    localparam int SUB_LO = 6;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;

    localparam logic [5:0] MAJOR_OPCODE_GROUP3 = 6'h1f;
    localparam logic [5:0] FUNC_CLASS_A = 6'h18;
    localparam logic [5:0] FUNC_CLASS_B = 6'h14;
    localparam logic [4:0] SUB_HALF_WRAP = 5'h0c;
    localparam logic [4:0] SUB_HALF_CLIP = 5'h0e;
    localparam logic [4:0] SUB_Q15_UPPER = 5'h1c;
    localparam logic [4:0] SUB_Q15_LOWER = 5'h1d;

    // ************************************************************
    // arithmetic limits
    // ************************************************************
    localparam logic signed [31:0] HALF_MAX = 32'sh0000_7fff;
    localparam logic signed [31:0] HALF_MIN = 32'shffff_8000;
    localparam logic [15:0] CLIP_POS = 16'h7fff;
    localparam logic [15:0] CLIP_NEG = 16'h8000;
    localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;
    localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;

    // ************************************************************
    // control register and reset values
    // ************************************************************
    localparam int OUFLAG_BIT = 21;
    localparam logic [31:0] OUFLAG_MASK = 32'h0020_0000;
    localparam logic [63:0] DATA_RST = 64'h0;
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [4:0] DEST_RST = 5'h0;
    localparam int UPPER_PAIR_BASE = 32;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_HALF_WRAP,
        OP_HALF_CLIP,
        OP_Q15_UPPER,
        OP_Q15_LOWER
    } mul_op_t;

endpackage

// file: design/lane_if.sv
// Purpose: carries one halfword element pair and its products
// Assumes: purely combinational lane
// Notes: core side drives operands, lane side answers
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
    logic signed [15:0] opa;
    logic signed [15:0] opb;
    logic [15:0] wrap16;
    logic [15:0] clip16;
    logic int_ovf;
    logic [31:0] q31;
    logic q_sat;

    modport lane (input opa, input opb, output wrap16, output clip16,
                  output int_ovf, output q31, output q_sat);
    modport core (output opa, output opb, input wrap16, input clip16,
                  input int_ovf, input q31, input q_sat);
endinterface
`default_nettype wire

// file: design/half_lane.sv
// Purpose: one signed 16x16 element product in all result forms
// Assumes: operands stable within the cycle
// Notes: no state; the core registers the chosen form
`timescale 1ns/1ps
`default_nettype none
module half_lane
    import simd_mul_pkg::*;
(
    // element pair
    lane_if.lane port
);

    logic signed [31:0] prod;
    logic both_min;

    always_comb begin
        // signed product at full 32-bit width
        prod = port.opa * port.opb;
        both_min = (port.opa == Q15_MINUS_ONE) &&
                   (port.opb == Q15_MINUS_ONE);
        port.wrap16 = prod[15:0];
        port.int_ovf = (prod > HALF_MAX) || (prod < HALF_MIN);
        if (prod > HALF_MAX) begin
            port.clip16 = CLIP_POS;
        end else if (prod < HALF_MIN) begin
            port.clip16 = CLIP_NEG;
        end else begin
            port.clip16 = prod[15:0];
        end
        // only -1.0 * -1.0 escapes the Q31 range
        port.q_sat = both_min;
        if (both_min) begin
            port.q31 = Q31_MAX;
        end else begin
            port.q31 = {prod[30:0], 1'b0};
        end
    end

endmodule
`default_nettype wire

// file: design/simd_halfword_multiplier.sv
// Purpose: packed halfword and Q15 pair multiply execution stage
// Assumes: pipeline presents one decoded instruction per valid cycle
// Notes: one registered stage; results and flags one cycle after issue
// Behaviour
// - signed 16x16 element products, 32-bit wide
// - wrap form keeps low 16 bits
// - clip form saturates to 0x7fff or 0x8000
// - clip overflow sets sticky bit 21
// - wrap overflow also sets sticky bit 21
// - base accumulator clobbered, others untouched
// - only reserved and disabled exceptions raised
// - upper pair uses bits 63..32
// - lower pair uses bits 31..0
// - fractional product shifted left one bit
// - both 0x8000 gives 0x7fffffff
// - fractional clamp sets sticky bit 21
// - decode wrap and clip under class a
// - decode upper and lower under class b
`timescale 1ns/1ps
`default_nettype none
module simd_halfword_multiplier
    import simd_mul_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // issue
    input wire logic issue_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] src_reg_a,
    input wire logic [63:0] src_reg_b,
    input wire logic dsp_enable,
    input wire logic wide_enable,
    // control register image
    input wire logic [31:0] signal_proc_control,
    // result
    output logic result_valid,
    output logic [4:0] result_dest,
    output logic [63:0] result_data,
    output logic ctrl_write,
    output logic [31:0] ctrl_next,
    output logic base_sum_clobber,
    // exceptions
    output logic exc_reserved,
    output logic exc_dsp_disabled
);

    // ************************************************************
    // decode
    // ************************************************************
    mul_op_t op;
    logic [5:0] major;
    logic [5:0] func;
    logic [4:0] sub;

    always_comb begin
        major = instr_word[MAJOR_HI:MAJOR_LO];
        func = instr_word[FUNC_HI:FUNC_LO];
        sub = instr_word[SUB_HI:SUB_LO];
        op = OP_NONE;
        if (issue_valid && major == MAJOR_OPCODE_GROUP3) begin
            if (func == FUNC_CLASS_A) begin
                if (sub == SUB_HALF_WRAP) begin
                    op = OP_HALF_WRAP;
                end else if (sub == SUB_HALF_CLIP) begin
                    op = OP_HALF_CLIP;
                end
            end else if (func == FUNC_CLASS_B) begin
                if (sub == SUB_Q15_UPPER) begin
                    op = OP_Q15_UPPER;
                end else if (sub == SUB_Q15_LOWER) begin
                    op = OP_Q15_LOWER;
                end
            end
        end
    end

    // ************************************************************
    // element lanes
    // ************************************************************
    logic [15:0] wrap_el [2];
    logic [15:0] clip_el [2];
    logic [31:0] q_el [2];
    logic [1:0] int_ovf_el;
    logic [1:0] q_sat_el;
    logic upper_sel;

    // operands beyond the documented format give undefined
    // results; no check is made on them
    assign upper_sel = (op == OP_Q15_UPPER);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            lane_if lif ();
            // upper pair form reads bits 63..32, else 31..0
            assign lif.opa = upper_sel ?
                src_reg_a[UPPER_PAIR_BASE + 16*gi +: 16] :
                src_reg_a[16*gi +: 16];
            assign lif.opb = upper_sel ?
                src_reg_b[UPPER_PAIR_BASE + 16*gi +: 16] :
                src_reg_b[16*gi +: 16];
            assign wrap_el[gi] = lif.wrap16;
            assign clip_el[gi] = lif.clip16;
            assign q_el[gi] = lif.q31;
            assign int_ovf_el[gi] = lif.int_ovf;
            assign q_sat_el[gi] = lif.q_sat;
            half_lane u_lane (
                .port(lif)
            );
        end
    endgenerate

    // ************************************************************
    // result selection and registering
    // ************************************************************
    logic result_valid_ff, nxt_result_valid;
    logic [4:0] result_dest_ff, nxt_result_dest;
    logic [63:0] result_data_ff, nxt_result_data;
    logic ctrl_write_ff, nxt_ctrl_write;
    logic [31:0] ctrl_next_ff, nxt_ctrl_next;
    logic clobber_ff, nxt_clobber;
    logic exc_ri_ff, nxt_exc_ri;
    logic exc_dis_ff, nxt_exc_dis;
    logic [31:0] packed_half;
    logic flag_event;
    logic wide_op;

    always_comb begin
        packed_half = 32'h0;
        flag_event = 1'b0;
        nxt_result_data = result_data_ff;
        nxt_result_dest = result_dest_ff;
        wide_op = (op == OP_Q15_UPPER) || (op == OP_Q15_LOWER);
        unique case (op)
            OP_HALF_WRAP: begin
                packed_half = {wrap_el[1], wrap_el[0]};
                flag_event = |int_ovf_el;
            end
            OP_HALF_CLIP: begin
                packed_half = {clip_el[1], clip_el[0]};
                flag_event = |int_ovf_el;
            end
            OP_Q15_UPPER, OP_Q15_LOWER: begin
                flag_event = |q_sat_el;
            end
            OP_NONE: begin
                packed_half = 32'h0;
            end
        endcase
        // exceptions never depend on operand values
        // reserved takes priority over disabled
        nxt_exc_ri = (op != OP_NONE) && wide_op && !wide_enable;
        nxt_exc_dis = (op != OP_NONE) && !nxt_exc_ri &&
                      !dsp_enable;
        nxt_result_valid = (op != OP_NONE) && !nxt_exc_ri && !nxt_exc_dis;
        if (nxt_result_valid) begin
            nxt_result_dest = instr_word[DEST_HI:DEST_LO];
            if (wide_op) begin
                nxt_result_data = {q_el[1], q_el[0]};
            end else begin
                nxt_result_data = {{32{packed_half[31]}},
                                   packed_half};
            end
        end
        // or-in only: no field is ever cleared here
        nxt_ctrl_write = nxt_result_valid && flag_event;
        nxt_ctrl_next = signal_proc_control | OUFLAG_MASK;
        // base sum register left unpredictable; no accumulator is
        // written, so the other accumulators keep their contents
        nxt_clobber = nxt_result_valid;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_valid_ff <= 1'b0;
            result_dest_ff <= DEST_RST;
            result_data_ff <= DATA_RST;
            ctrl_write_ff <= 1'b0;
            ctrl_next_ff <= CTRL_RST;
            clobber_ff <= 1'b0;
            exc_ri_ff <= 1'b0;
            exc_dis_ff <= 1'b0;
        end else begin
            result_valid_ff <= nxt_result_valid;
            result_dest_ff <= nxt_result_dest;
            result_data_ff <= nxt_result_data;
            ctrl_write_ff <= nxt_ctrl_write;
            ctrl_next_ff <= nxt_ctrl_next;
            clobber_ff <= nxt_clobber;
            exc_ri_ff <= nxt_exc_ri;
            exc_dis_ff <= nxt_exc_dis;
        end
    end

    assign result_valid = result_valid_ff;
    assign result_dest = result_dest_ff;
    assign result_data = result_data_ff;
    assign ctrl_write = ctrl_write_ff;
    assign ctrl_next = ctrl_next_ff;
    assign base_sum_clobber = clobber_ff;
    assign exc_reserved = exc_ri_ff;
    assign exc_dsp_disabled = exc_dis_ff;

    // ************************************************************
    // checks
    // ************************************************************
    logic good_issue;
    assign good_issue = nxt_result_valid;

    property p_elem_product;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_HALF_WRAP) |=> result_data[15:0] ==
            16'($signed($past(src_reg_a[15:0])) *
                $signed($past(src_reg_b[15:0])));
    endproperty
    a_elem_product: assert property (p_elem_product)
        else $error("wrap low element product wrong");

    property p_wrap_upper;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_HALF_WRAP) |=> result_data[31:16] ==
            16'($signed($past(src_reg_a[31:16])) *
                $signed($past(src_reg_b[31:16])));
    endproperty
    a_wrap_upper: assert property (p_wrap_upper)
        else $error("wrap upper element misplaced");

    property p_clip_pos;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_HALF_CLIP && src_reg_a[15:0] == CLIP_NEG
         && src_reg_b[15:0] == CLIP_NEG) |=> result_data[15:0] == CLIP_POS;
    endproperty
    a_clip_pos: assert property (p_clip_pos)
        else $error("positive overflow not clipped");

    property p_clip_flag;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_HALF_CLIP && |int_ovf_el) |=>
            ctrl_write && ctrl_next[OUFLAG_BIT];
    endproperty
    a_clip_flag: assert property (p_clip_flag)
        else $error("clip overflow did not set sticky bit");

    property p_wrap_flag;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && (op == OP_HALF_WRAP || op == OP_HALF_CLIP)) |=>
            ctrl_write == |$past(int_ovf_el);
    endproperty
    a_wrap_flag: assert property (p_wrap_flag)
        else $error("halfword sticky write mismatch");

    // a refused instruction must not disturb the base sum register
    property p_clobber;
        @(posedge core_clk) disable iff (!arst_n)
        (op != OP_NONE) |=>
            base_sum_clobber == !(exc_reserved || exc_dsp_disabled);
    endproperty
    a_clobber: assert property (p_clobber)
        else $error("clobber mark not with result");

    property p_exc_only_enables;
        @(posedge core_clk) disable iff (!arst_n)
        (op != OP_NONE && dsp_enable && wide_enable) |=>
            !exc_reserved && !exc_dsp_disabled && result_valid;
    endproperty
    a_exc_only_enables: assert property (p_exc_only_enables)
        else $error("exception without enable cause");

    property p_upper_place;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_Q15_UPPER && src_reg_a[63:48] ==
         Q15_MINUS_ONE && src_reg_b[63:48] == Q15_MINUS_ONE) |=>
            result_data[63:32] == Q31_MAX && ctrl_write;
    endproperty
    a_upper_place: assert property (p_upper_place)
        else $error("upper pair clamp misplaced");

    property p_lower_shift;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && op == OP_Q15_LOWER &&
         !(src_reg_a[15:0] == Q15_MINUS_ONE &&
           src_reg_b[15:0] == Q15_MINUS_ONE)) |=>
            // the int factor widens the product to 32 signed bits
            $signed(result_data[31:0]) ==
            $signed($past(src_reg_a[15:0])) *
            $signed($past(src_reg_b[15:0])) * 2;
    endproperty
    a_lower_shift: assert property (p_lower_shift)
        else $error("lower pair Q31 word wrong");

    property p_sign_ext;
        @(posedge core_clk) disable iff (!arst_n)
        (good_issue && (op == OP_HALF_WRAP || op == OP_HALF_CLIP)) |=>
            result_data[63:32] == {32{result_data[31]}};
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("halfword result not sign extended");

    property p_ctrl_keep;
        @(posedge core_clk) disable iff (!arst_n)
        ctrl_write |-> (ctrl_next & ~OUFLAG_MASK) ==
            ($past(signal_proc_control) & ~OUFLAG_MASK)
            && ctrl_next[OUFLAG_BIT];
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep)
        else $error("control fields disturbed");

endmodule
`default_nettype wire

// file: bench/pipe_model.sv
// Purpose: pipeline side issuing decoded multiply requests
// Assumes: called just after a falling edge of core_clk
// Notes: operands scramble while nothing is issued
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
    // issue
    output logic issue_valid,
    output logic [31:0] instr_word,
    output logic [63:0] src_reg_a,
    output logic [63:0] src_reg_b,
    output logic dsp_enable,
    output logic wide_enable,
    output logic [31:0] signal_proc_control
);
    initial begin
        issue_valid = 1'b0;
        instr_word = 32'h0;
        src_reg_a = 64'h0;
        src_reg_b = 64'h0;
        dsp_enable = 1'b0;
        wide_enable = 1'b0;
        signal_proc_control = 32'h0;
    end

    // idle cycles invert operands so stale values never pass as valid
    task automatic drive(logic v, logic [31:0] iw, logic [63:0] a,
                         logic [63:0] b, logic dsp, logic wide,
                         logic [31:0] ctl);
        issue_valid = v;
        instr_word = v ? iw : ~instr_word;
        src_reg_a = v ? a : ~src_reg_a;
        src_reg_b = v ? b : ~src_reg_b;
        dsp_enable = dsp;
        wide_enable = wide;
        signal_proc_control = v ? ctl : ~signal_proc_control;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench of the halfword multiplier
// Assumes: one-cycle answer latency, inputs change at falling edge
// Notes: each issue checks the answer of the previous cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk, arst_n;
    logic issue_valid, dsp_enable, wide_enable;
    logic [31:0] instr_word, signal_proc_control, ctrl_next;
    logic [63:0] src_reg_a, src_reg_b, result_data;
    logic result_valid, ctrl_write, base_sum_clobber;
    logic exc_reserved, exc_dsp_disabled;
    logic [4:0] result_dest;
    int n_fail, n_tests;
    logic e_res, e_rsv, e_dis, e_cw;
    logic [63:0] e_data;
    logic [31:0] e_ctrl;
    logic [4:0] e_dest, dest_n;

    simd_halfword_multiplier dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .issue_valid(issue_valid), .instr_word(instr_word),
        .src_reg_a(src_reg_a), .src_reg_b(src_reg_b),
        .dsp_enable(dsp_enable), .wide_enable(wide_enable),
        .signal_proc_control(signal_proc_control),
        .result_valid(result_valid), .result_dest(result_dest),
        .result_data(result_data), .ctrl_write(ctrl_write),
        .ctrl_next(ctrl_next), .base_sum_clobber(base_sum_clobber),
        .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));

    pipe_model pipe_u (.issue_valid(issue_valid), .instr_word(instr_word),
        .src_reg_a(src_reg_a), .src_reg_b(src_reg_b),
        .dsp_enable(dsp_enable), .wide_enable(wide_enable),
        .signal_proc_control(signal_proc_control));

    // ************************************************************
    // reference arithmetic and checks
    // ************************************************************
    function automatic logic [16:0] half_ref(logic [15:0] a, logic [15:0] b,
                                             logic clip);
        logic signed [31:0] p;
        logic ovf;
        p = $signed(a) * $signed(b);
        ovf = p > 32'sh0000_7fff || p < 32'shffff_8000;
        if (clip && ovf) return {1'b1, p < 0 ? 16'h8000 : 16'h7fff};
        return {ovf, p[15:0]};
    endfunction

    function automatic logic [32:0] q_ref(logic [15:0] a, logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (a == 16'h8000 && b == 16'h8000) return {1'b1, 32'h7fff_ffff};
        return {1'b0, p[30:0], 1'b0};
    endfunction

    // 32-bit vectors arrive sign-extended
    function automatic logic [63:0] sx(logic [31:0] w);
        return {{32{w[31]}}, w};
    endfunction

    task automatic cmp(string what, logic [63:0] e, logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // kind: 0 wrap, 1 clip, 2 upper, 3 lower, 4/6 undecoded, 5 idle
    task automatic go(int kind, logic [63:0] a, logic [63:0] b,
                      logic dsp, logic wide);
        logic [16:0] h1, h0;
        logic [32:0] q1, q0;
        logic [4:0] sub;
        logic [5:0] fn;
        logic [31:0] ctl;
        logic q15, ovf;
        @(negedge core_clk);
        cmp("result_valid", e_res, result_valid);
        cmp("exc_reserved", e_rsv, exc_reserved);
        cmp("exc_dsp_disabled", e_dis, exc_dsp_disabled);
        cmp("base_sum_clobber", e_res, base_sum_clobber);
        cmp("ctrl_write", e_cw, ctrl_write);
        if (e_res) cmp("result_data", e_data, result_data);
        if (e_res) cmp("result_dest", {59'h0, e_dest}, {59'h0, result_dest});
        if (e_cw) cmp("ctrl_next", {32'h0, e_ctrl}, {32'h0, ctrl_next});
        q15 = kind == 2 || kind == 3;
        fn = (q15 || kind == 6) ? 6'h14 : 6'h18;
        case (kind)
            0, 6: sub = 5'h0c;
            1: sub = 5'h0e;
            2: sub = 5'h1c;
            3: sub = 5'h1d;
            default: sub = 5'h0d;
        endcase
        dest_n = dest_n + 5'h05;
        ctl = 32'h5a5a_5a5a ^ {6'h0, dest_n, 21'h0};
        h1 = half_ref(a[31:16], b[31:16], kind == 1);
        h0 = half_ref(a[15:0], b[15:0], kind == 1);
        q1 = kind == 2 ? q_ref(a[63:48], b[63:48]) : q_ref(a[31:16], b[31:16]);
        q0 = kind == 2 ? q_ref(a[47:32], b[47:32]) : q_ref(a[15:0], b[15:0]);
        ovf = q15 ? (q1[32] | q0[32]) : (h1[16] | h0[16]);
        e_rsv = kind < 4 && q15 && !wide;
        e_dis = kind < 4 && !e_rsv && !dsp;
        e_res = kind < 4 && !e_rsv && !e_dis;
        e_cw = e_res && ovf;
        e_data = q15 ? {q1[31:0], q0[31:0]} : {{32{h1[15]}}, h1[15:0], h0[15:0]};
        e_dest = dest_n;
        e_ctrl = ctl | 32'h0020_0000;
        pipe_u.drive(kind != 5, {6'h1f, 5'h03, 5'h07, dest_n, sub, fn},
                     a, b, dsp, wide, ctl);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_half();
        logic [31:0] av [5] = '{32'h7fff_0003, 32'h8000_8000, 32'hff00_00b5,
                                32'h8000_fffe, 32'h00b5_fffe};
        logic [31:0] bv [5] = '{32'h7fff_0004, 32'h0001_8000, 32'h0100_00b5,
                                32'hffff_0003, 32'h00b5_0003};
        foreach (av[i]) begin
            go(0, sx(av[i]), sx(bv[i]), 1'b1, 1'b0);
            go(1, sx(av[i]), sx(bv[i]), 1'b1, 1'b0);
        end
        go(5, 64'h0, 64'h0, 1'b1, 1'b1);
        $display("test halfword pairs done");
    endtask

    task automatic t_q15();
        go(2, 64'h8000_8000_4000_8000, 64'h8000_7fff_4000_8000, 1'b1, 1'b1);
        go(3, 64'h8000_8000_4000_8000, 64'h8000_7fff_4000_8000, 1'b1, 1'b1);
        go(2, 64'h4000_c000_8000_7fff, 64'h4000_0002_8000_8000, 1'b1, 1'b1);
        go(3, 64'h4000_c000_8000_7fff, 64'h4000_0002_8000_8000, 1'b1, 1'b1);
        go(5, 64'h0, 64'h0, 1'b1, 1'b1);
        $display("test q15 pairs done");
    endtask

    task automatic t_refuse();
        go(2, 64'h8000_8000_8000_8000, 64'h8000_8000_8000_8000, 1'b0, 1'b0);
        go(3, 64'h8000_8000_8000_8000, 64'h8000_8000_8000_8000, 1'b1, 1'b0);
        go(0, sx(32'h7fff_7fff), sx(32'h7fff_7fff), 1'b0, 1'b1);
        go(3, 64'h1, 64'h1, 1'b0, 1'b1);
        go(1, sx(32'h8000_8000), sx(32'h8000_8000), 1'b0, 1'b0);
        go(4, sx(32'h7fff_7fff), sx(32'h7fff_7fff), 1'b1, 1'b1);
        go(6, sx(32'h7fff_7fff), sx(32'h7fff_7fff), 1'b1, 1'b1);
        go(5, 64'h0, 64'h0, 1'b1, 1'b1);
        $display("test refusals done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        arst_n = 1'b0;
        n_fail = 0;
        n_tests = 0;
        {e_res, e_rsv, e_dis, e_cw} = 4'h0;
        dest_n = 5'h00;
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        t_half();
        t_q15();
        t_refuse();
        tally_and_finish();
    end

    // tests need about 40 cycles; a fifty-fold margin
    initial begin
        repeat (2000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
